//--- hdl/event_counter_timer_unit.sv
// event counter and pulse timer unit with a classic wishbone register slave
// Behaviour
// - source off reports idle
// - armed without trigger reports waiting
// - counting toward length reports active
// - reaching length reports done
// - counter reaching maximum count reports wrapped
// - source off ignores every trigger
// - acquisition, frame, exposure events start counters
// - numbered io line transition starts counter
// - other counter end starts counter
// - timer end starts counter
// - rising, falling or any edge activation
// - level modes: counters count only during level, timers only start on it
// - several timers chosen by selector
// - timer end: pulse, inactive, stays stopped
// - pulse length accepted in native ticks
// - native and us lengths stay consistent
// - delay after trigger before pulse
// - native delay consistent with us delay
// - selected timer elapsed us readable
// - counter end: pulse, inactive, halts
// - clear catches value into capture
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
module event_counter_timer_unit
  import evt_timer_pkg::*;
#(
  parameter int NC = 2,  // counters
  parameter int NT = 2,  // timers
  parameter int NL = 4,  // io lines
  parameter int CW = 32  // counter and timer width
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // wishbone slave
  input  wire logic                  cyc,
  input  wire logic                  stb,
  input  wire logic                  we,
  input  wire logic [7:0]            adr,
  input  wire logic [3:0]            sel,
  input  wire logic [31:0]           dat_wr,
  output logic      [31:0]           dat_rd,
  output logic                       ack,
  // trigger inputs from acquisition logic and pins
  input  wire logic [ACQ_EVENTS-1:0] acq_events,
  input  wire logic [NL-1:0]         io_line,
  // counter and timer outputs
  output logic      [NC-1:0]         count_running_signal,
  output logic      [NC-1:0]         count_finish_event,
  output logic      [NT-1:0]         pulse_running_signal,
  output logic      [NT-1:0]         pulse_finish_event
);

  // ===========================================================
  // sizes and types
  localparam int SW   = 1 + ACQ_EVENTS + NL + NC + NT; // trigger vector width
  localparam int CSW  = (NC > 1) ? $clog2(NC) : 1;     // counter select width
  localparam int TSW  = (NT > 1) ? $clog2(NT) : 1;     // timer select width
  localparam int PW   = $clog2(TICK_CYCLES + 1);       // prescaler width
  localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);
  typedef struct packed {
    logic [4:0]    src;   // start source
    logic [2:0]    act;   // activation type
    logic [CW-1:0] len;   // target length
    logic [CW-1:0] val;   // running count
    logic [CW-1:0] capt;  // value caught at clear
    cnt_state_t    st;    // state
    logic          fin;   // finish pulse
  } cnt_t;
  typedef struct packed {
    logic [4:0]    src;   // start source
    logic [2:0]    act;   // activation type
    logic [CW-1:0] len;   // pulse length, native ticks
    logic [CW-1:0] dly;   // delay, native ticks
    logic [CW-1:0] val;   // elapsed native ticks
    logic [PW-1:0] pre;   // clock prescaler to native tick
    tmr_state_t    st;    // state
    logic          fin;   // finish pulse
  } tmr_t;
  typedef struct packed {
    logic [ACQ_EVENTS-1:0] acq_m;  // first sync stage
    logic [ACQ_EVENTS-1:0] acq_s;  // second sync stage
    logic [NL-1:0]         ln_m;   // first sync stage
    logic [NL-1:0]         ln_s;   // second sync stage
    logic [SW-1:0]         prev;   // trigger levels last cycle
    logic [CSW-1:0]        csel;   // counter select
    logic [TSW-1:0]        tsel;   // timer select
    cnt_t [NC-1:0]         cnt;    // counters
    tmr_t [NT-1:0]         tmr;    // timers
    logic                  ack;    // bus answer
    logic [31:0]           dat;    // read data
  } st_t;
  st_t q, n; // registered state and its next value
  // ===========================================================
  // helpers
  // pick one trigger bit by source code, zero beyond the vector
  function automatic logic pick(input logic [SW-1:0] v, input logic [4:0] s);
    logic r;
    r = 1'b0;
    for (int k = 0; k < SW; k++) begin
      if (s == 5'(k)) begin
        r = v[k];
      end
    end
    return r;
  endfunction
  // edge start per activation
  function automatic logic edge_go(input logic [2:0] a, input logic r, input logic f);
    return (a == ACT_RISE && r) || (a == ACT_FALL && f) || (a == ACT_ANY && (r || f));
  endfunction
  // level held per activation
  function automatic logic level_on(input logic [2:0] a, input logic l);
    return (a == ACT_HIGH && l) || (a == ACT_LOW && !l);
  endfunction
  // byte lane merge of a write
  function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] w, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = w[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ===========================================================
  // trigger vector: off, acquisition, lines, counter ends, timer ends
  logic [SW-1:0] lv;   // trigger levels
  logic [SW-1:0] rise; // one-cycle rising edges
  logic [SW-1:0] fall; // one-cycle falling edges
  logic [NC-1:0] cfin; // counter finish levels
  logic [NT-1:0] tfin; // timer finish levels
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      cfin[i] = q.cnt[i].fin;
    end
    for (int i = 0; i < NT; i++) begin
      tfin[i] = q.tmr[i].fin;
    end
    lv   = {tfin, cfin, q.ln_s, q.acq_s, 1'b0};
    rise = lv & ~q.prev;
    fall = ~lv & q.prev;
  end

  // ===========================================================
  // next state
  logic        req;  // new bus request
  logic [31:0] wv;   // merged write value
  logic [31:0] rd;   // read mux
  cnt_t        c;    // selected counter
  tmr_t        t;    // selected timer
  always_comb begin
    n     = q;
    n.ack = 1'b0;
    n.acq_m = acq_events;
    n.acq_s = q.acq_m;
    n.ln_m  = io_line;
    n.ln_s  = q.ln_m;
    n.prev  = lv;
    // counters
    for (int i = 0; i < NC; i++) begin
      n.cnt[i].fin = 1'b0;
      if (q.cnt[i].src == SRC_OFF) begin
        n.cnt[i].st = C_IDLE;
      end else begin
        unique case (q.cnt[i].st)
          C_IDLE: begin
            n.cnt[i].st = C_ARMED;
          end
          C_ARMED: begin
            if (edge_go(q.cnt[i].act, pick(rise, q.cnt[i].src), pick(fall, q.cnt[i].src))) begin
              n.cnt[i].val = '0;
              n.cnt[i].st  = C_ACTIVE;
            end else if (level_on(q.cnt[i].act, pick(lv, q.cnt[i].src))) begin
              n.cnt[i].st = C_ACTIVE;
            end
          end
          C_ACTIVE: begin
            if (q.cnt[i].act >= ACT_HIGH && !level_on(q.cnt[i].act, pick(lv, q.cnt[i].src))) begin
              n.cnt[i].st = C_ARMED;
            end else if (q.cnt[i].val == q.cnt[i].len) begin
              n.cnt[i].st  = C_DONE;
              n.cnt[i].fin = 1'b1;
            end else if (&q.cnt[i].val) begin
              n.cnt[i].st = C_WRAPPED;
            end else begin
              n.cnt[i].val = q.cnt[i].val + 1'b1;
            end
          end
          C_DONE, C_WRAPPED: begin
            if (edge_go(q.cnt[i].act, pick(rise, q.cnt[i].src), pick(fall, q.cnt[i].src)) ||
                level_on(q.cnt[i].act, pick(lv, q.cnt[i].src))) begin
              n.cnt[i].val = '0;
              n.cnt[i].st  = C_ACTIVE;
            end
          end
          default: n.cnt[i].st = C_IDLE;
        endcase
      end
    end
    // timers
    for (int i = 0; i < NT; i++) begin
      n.tmr[i].fin = 1'b0;
      n.tmr[i].pre = (q.tmr[i].pre == TICK_LAST) ? '0 : q.tmr[i].pre + 1'b1;
      if (q.tmr[i].src == SRC_OFF) begin
        n.tmr[i].st = T_IDLE;
      end else begin
        unique case (q.tmr[i].st)
          T_IDLE: begin
            n.tmr[i].st = T_ARMED;
          end
          T_ARMED, T_DONE: begin
            if (edge_go(q.tmr[i].act, pick(rise, q.tmr[i].src), pick(fall, q.tmr[i].src)) ||
                level_on(q.tmr[i].act, pick(lv, q.tmr[i].src))) begin
              n.tmr[i].val = '0;
              n.tmr[i].pre = '0;
              n.tmr[i].st  = T_DELAY;
            end
          end
          T_DELAY: begin
            if (q.tmr[i].val == q.tmr[i].dly) begin
              n.tmr[i].val = '0;
              n.tmr[i].pre = '0;
              n.tmr[i].st  = T_ACTIVE;
            end else if (q.tmr[i].pre == TICK_LAST) begin
              n.tmr[i].val = q.tmr[i].val + 1'b1;
            end
          end
          T_ACTIVE: begin
            if (q.tmr[i].val == q.tmr[i].len) begin
              n.tmr[i].st  = T_DONE;
              n.tmr[i].fin = 1'b1;
            end else if (q.tmr[i].pre == TICK_LAST) begin
              n.tmr[i].val = q.tmr[i].val + 1'b1;
            end
          end
          default: n.tmr[i].st = T_IDLE;
        endcase
      end
    end
    // bus access, taken once per request
    req = cyc && stb && !q.ack;
    c   = q.cnt[q.csel];
    t   = q.tmr[q.tsel];
    wv  = 32'h0;
    rd  = 32'h0;
    unique case (adr)
      OFS_SELECT: begin
        rd[BIT_CNT_SEL +: CSW] = q.csel;
        rd[BIT_TMR_SEL +: TSW] = q.tsel;
      end
      OFS_CNT_SOURCE:  rd[4:0] = c.src;
      OFS_CNT_ACT:     rd[2:0] = c.act;
      OFS_CNT_LENGTH:  rd = 32'(c.len);
      OFS_CNT_VALUE:   rd = 32'(c.val);
      OFS_CNT_CAPT:    rd = 32'(c.capt);
      // state order idle..wrapped matches the readout codes
      OFS_CNT_STATE:   rd[2:0] = 3'(c.st);
      OFS_TMR_SOURCE:  rd[4:0] = t.src;
      OFS_TMR_ACT:     rd[2:0] = t.act;
      OFS_TMR_LEN_US:  rd = 32'(t.len >> NAT_PER_US_SHIFT);
      OFS_TMR_LEN_NAT: rd = 32'(t.len);
      OFS_TMR_DLY_US:  rd = 32'(t.dly >> NAT_PER_US_SHIFT);
      OFS_TMR_DLY_NAT: rd = 32'(t.dly);
      OFS_TMR_ELAPSED: begin
        if (t.st == T_ACTIVE || t.st == T_DONE) begin
          rd = 32'(t.val >> NAT_PER_US_SHIFT);
        end
      end
      OFS_TMR_STATE: begin
        unique case (t.st)
          T_IDLE:           rd[2:0] = RD_IDLE;
          T_ARMED, T_DELAY: rd[2:0] = RD_ARMED;
          T_ACTIVE:         rd[2:0] = RD_ACTIVE;
          T_DONE:           rd[2:0] = RD_DONE;
          default:          rd[2:0] = RD_IDLE;
        endcase
      end
      default: rd = 32'h0;
    endcase
    if (req) begin
      n.ack = 1'b1;
      n.dat = rd;
      wv    = lanes(rd, dat_wr, sel);
      if (we) begin
        unique case (adr)
          OFS_SELECT: begin
            n.csel = wv[BIT_CNT_SEL +: CSW];
            n.tsel = wv[BIT_TMR_SEL +: TSW];
          end
          OFS_CNT_SOURCE:  n.cnt[q.csel].src = wv[4:0];
          OFS_CNT_ACT:     n.cnt[q.csel].act = wv[2:0];
          OFS_CNT_LENGTH:  n.cnt[q.csel].len = CW'(wv);
          OFS_COMMAND: begin
            if (wv[BIT_CNT_CLEAR]) begin
              n.cnt[q.csel].capt = c.val;
              n.cnt[q.csel].val  = '0;
              n.cnt[q.csel].st   = (c.src == SRC_OFF) ? C_IDLE :
                                   (c.act >= ACT_HIGH) ? C_ARMED : C_ACTIVE;
            end
            if (wv[BIT_TMR_CLEAR]) begin
              n.tmr[q.tsel].val = '0;
              n.tmr[q.tsel].st  = (t.src == SRC_OFF) ? T_IDLE : T_ARMED;
            end
          end
          OFS_TMR_SOURCE:  n.tmr[q.tsel].src = wv[4:0];
          OFS_TMR_ACT:     n.tmr[q.tsel].act = wv[2:0];
          OFS_TMR_LEN_US:  n.tmr[q.tsel].len = CW'(wv) << NAT_PER_US_SHIFT;
          OFS_TMR_LEN_NAT: n.tmr[q.tsel].len = CW'(wv);
          OFS_TMR_DLY_US:  n.tmr[q.tsel].dly = CW'(wv) << NAT_PER_US_SHIFT;
          OFS_TMR_DLY_NAT: n.tmr[q.tsel].dly = CW'(wv);
          default: n.ack = 1'b1;
        endcase
      end
    end
  end

  // ===========================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ===========================================================
  // outputs
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      count_running_signal[i] = (q.cnt[i].st == C_ACTIVE);
      count_finish_event[i]   = q.cnt[i].fin;
    end
    for (int i = 0; i < NT; i++) begin
      pulse_running_signal[i] = (q.tmr[i].st == T_ACTIVE);
      pulse_finish_event[i]   = q.tmr[i].fin;
    end
    dat_rd = q.dat;
    ack    = q.ack;
  end

endmodule // event_counter_timer_unit

//--- hdl/evt_timer_pkg.sv
// constants shared by the event counter and timer unit
package evt_timer_pkg;

  // ===========================================================
  // register byte offsets
  localparam logic [7:0] OFS_SELECT      = 8'h00; // [0] counter select, [8] timer select
  localparam logic [7:0] OFS_CNT_SOURCE  = 8'h04; // selected counter start source
  localparam logic [7:0] OFS_CNT_ACT     = 8'h08; // selected counter activation
  localparam logic [7:0] OFS_CNT_LENGTH  = 8'h0c; // selected counter target length
  localparam logic [7:0] OFS_CNT_VALUE   = 8'h10; // selected counter value, read only
  localparam logic [7:0] OFS_CNT_CAPT    = 8'h14; // value caught at last clear, read only
  localparam logic [7:0] OFS_CNT_STATE   = 8'h18; // selected counter state, read only
  localparam logic [7:0] OFS_COMMAND     = 8'h1c; // [0] counter clear, [1] timer clear
  localparam logic [7:0] OFS_TMR_SOURCE  = 8'h20; // selected timer start source
  localparam logic [7:0] OFS_TMR_ACT     = 8'h24; // selected timer activation
  localparam logic [7:0] OFS_TMR_LEN_US  = 8'h28; // pulse length in microseconds
  localparam logic [7:0] OFS_TMR_LEN_NAT = 8'h2c; // pulse length in native ticks
  localparam logic [7:0] OFS_TMR_DLY_US  = 8'h30; // pulse delay in microseconds
  localparam logic [7:0] OFS_TMR_DLY_NAT = 8'h34; // pulse delay in native ticks
  localparam logic [7:0] OFS_TMR_ELAPSED = 8'h38; // elapsed pulse time in us, read only
  localparam logic [7:0] OFS_TMR_STATE   = 8'h3c; // selected timer state, read only

  // ===========================================================
  // field positions
  localparam int BIT_CNT_SEL   = 0;  // counter select in select register
  localparam int BIT_TMR_SEL   = 8;  // timer select in select register
  localparam int BIT_CNT_CLEAR = 0;  // counter clear in command register
  localparam int BIT_TMR_CLEAR = 1;  // timer clear in command register

  // ===========================================================
  // start source codes; lines, counters and timers follow in order
  localparam logic [4:0] SRC_OFF       = 5'h00; // source disabled
  localparam logic [4:0] SRC_ACQ_FIRST = 5'h01; // eight acquisition events from here
  localparam int         ACQ_EVENTS    = 8;     // acq trig/start/end, frame trig/start/end, exp start/end

  // activation codes
  localparam logic [2:0] ACT_RISE = 3'h0;
  localparam logic [2:0] ACT_FALL = 3'h1;
  localparam logic [2:0] ACT_ANY  = 3'h2;
  localparam logic [2:0] ACT_HIGH = 3'h3;
  localparam logic [2:0] ACT_LOW  = 3'h4;

  // state readout codes
  localparam logic [2:0] RD_IDLE    = 3'h0;
  localparam logic [2:0] RD_ARMED   = 3'h1;
  localparam logic [2:0] RD_ACTIVE  = 3'h2;
  localparam logic [2:0] RD_DONE    = 3'h3;
  localparam logic [2:0] RD_WRAPPED = 3'h4;

  // ===========================================================
  // timing: one native tick is half a microsecond
  localparam int CLK_PERIOD_NS  = 50;
  localparam int NATIVE_TICK_NS = 500;
  localparam int TICK_CYCLES    = NATIVE_TICK_NS / CLK_PERIOD_NS;
  localparam int NAT_PER_US_SHIFT = 1; // native = us << 1

  // counter and timer states
  typedef enum logic [2:0] {C_IDLE, C_ARMED, C_ACTIVE, C_DONE, C_WRAPPED} cnt_state_t;
  typedef enum logic [2:0] {T_IDLE, T_ARMED, T_DELAY, T_ACTIVE, T_DONE} tmr_state_t;

endpackage

//--- verif/event_counter_timer_unit_sva.sv
// checker for bus handshake and end-of-run behaviour
module event_counter_timer_unit_sva
  import evt_timer_pkg::*;
#(
  parameter int NC = 2,
  parameter int NT = 2,
  parameter int NL = 4,
  parameter int CW = 32
) (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst,
  // wishbone slave side
  input wire logic                  cyc,
  input wire logic                  stb,
  input wire logic                  we,
  input wire logic [7:0]            adr,
  input wire logic [3:0]            sel,
  input wire logic [31:0]           dat_wr,
  input wire logic [31:0]           dat_rd,
  input wire logic                  ack,
  // triggers and unit outputs
  input wire logic [ACQ_EVENTS-1:0] acq_events,
  input wire logic [NL-1:0]         io_line,
  input wire logic [NC-1:0]         count_running_signal,
  input wire logic [NC-1:0]         count_finish_event,
  input wire logic [NT-1:0]         pulse_running_signal,
  input wire logic [NT-1:0]         pulse_finish_event
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // bus handshake: one answer per request, next cycle
  a_ack_single_pulse: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  a_ack_answers_req: assert property (cyc && stb && !ack |=> ack)
    else $error("request not answered in the next cycle");
  a_ack_has_cause: assert property (ack |-> $past(cyc && stb))
    else $error("ack without a request");

  // ==========================================================
  // counter end: single pulse, run stops, run preceded it
  a_cnt_end_single: assert property ((count_finish_event & $past(count_finish_event)) == '0)
    else $error("counter finish longer than one cycle");
  a_cnt_end_quiet: assert property ((count_finish_event & count_running_signal) == '0)
    else $error("counter still running at its finish");
  a_cnt_end_after_run: assert property (count_finish_event[0] |-> $past(count_running_signal[0]))
    else $error("counter finish without a run before it");

  // ==========================================================
  // timer end: single pulse, pulse low, falls only for a cause
  a_tmr_end_single: assert property ((pulse_finish_event & $past(pulse_finish_event)) == '0)
    else $error("timer finish longer than one cycle");
  a_tmr_end_stops: assert property (pulse_finish_event[0] |-> !pulse_running_signal[0] ##1 !pulse_running_signal[0])
    else $error("timer pulse not stopped at its finish");
  a_tmr_fall_cause: assert property ($fell(pulse_running_signal[0]) |-> pulse_finish_event[0] || $past(cyc && stb && we))
    else $error("timer pulse ended without finish or write");

  // main scenarios reached
  c_cascade_end: cover property (count_finish_event[1]);
  c_timer_end: cover property (pulse_finish_event[0]);
  c_level_pause: cover property ($fell(count_running_signal[0]) && !count_finish_event[0]);
endmodule // event_counter_timer_unit_sva

bind event_counter_timer_unit event_counter_timer_unit_sva #(.NC(NC), .NT(NT), .NL(NL), .CW(CW)) u_sva (
  .core_clk(core_clk), .rst(rst), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
  .dat_wr(dat_wr), .dat_rd(dat_rd), .ack(ack), .acq_events(acq_events), .io_line(io_line),
  .count_running_signal(count_running_signal), .count_finish_event(count_finish_event),
  .pulse_running_signal(pulse_running_signal), .pulse_finish_event(pulse_finish_event)
);

//--- verif/testbench.sv
// self-checking bench for the event counter and timer unit
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %0t: got %0h expected %0h", $time, got, exp); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import evt_timer_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        ack;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_wr = 32'h0;
  logic [31:0] dat_rd;
  logic [31:0] rd;
  logic [7:0]  acq_events = 8'h00;
  logic [3:0]  io_line = 4'h0;
  logic [1:0]  crun, cfin, prun, pfin;
  int          bad_count = 0;
  int          checks_done = 0;
  int          ln, ln2, wt;

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  event_counter_timer_unit dut (
    .core_clk(core_clk), .rst(rst), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_wr(dat_wr), .dat_rd(dat_rd), .ack(ack), .acq_events(acq_events), .io_line(io_line),
    .count_running_signal(crun), .count_finish_event(cfin),
    .pulse_running_signal(prun), .pulse_finish_event(pfin)
  );

  // ==========================================================
  // one classic wishbone cycle; waits for ack, then idles a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_wr <= d;
    sel <= s;
    // this wait ends on ack; the watchdog catches an ack that never comes
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    rd = dat_rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK(rd, e)
  endtask
  // drives the trigger input behind source code s
  task automatic drive(input int s, input logic v);
    if (s <= ACQ_EVENTS) acq_events[s-1] <= v;
    else io_line[s-9] <= v;
  endtask
  // waits for a run on bit b, returns wait and high cycles
  task automatic run_len(input int b, input logic tmr, output int len, output int w);
    w = 0;
    len = 0;
    while ((tmr ? prun[b] : crun[b]) !== 1'b1 && w < 100) begin
      @(posedge core_clk);
      w++;
    end
    while ((tmr ? prun[b] : crun[b]) === 1'b1 && len < 5000) begin
      @(posedge core_clk);
      len++;
    end
  endtask
  // prints counts and verdict, ends the run
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // watchdog against a hang
  initial begin
    #(30000 * 50);
    bad_count++;
    test_done();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rchk(OFS_CNT_STATE, {29'h0, RD_IDLE});
    rchk(8'h40, 32'h0);
    wr(8'h40, 32'h1234_5678);
    rchk(8'h40, 32'h0);
    wr(OFS_TMR_LEN_US, 32'h5);
    rchk(OFS_TMR_LEN_NAT, 32'h5 << NAT_PER_US_SHIFT);
    wr(OFS_TMR_DLY_NAT, 32'h6);
    rchk(OFS_TMR_DLY_US, 32'h6 >> NAT_PER_US_SHIFT);
    wr(OFS_SELECT, 32'h100);
    rchk(OFS_TMR_LEN_NAT, 32'h0);
    wr(OFS_TMR_LEN_NAT, 32'h8);
    rchk(OFS_TMR_LEN_US, 32'h8 >> NAT_PER_US_SHIFT);
    wr(OFS_SELECT, 32'h0);
    rchk(OFS_TMR_LEN_US, 32'h5);
    bus(1'b1, OFS_CNT_LENGTH, 32'hffff_ff07, 4'h1);
    rchk(OFS_CNT_LENGTH, 32'h7);
    rchk(OFS_COMMAND, 32'h0);
    // every acquisition event and io line starts counter 0
    for (int s = 1; s <= 12; s++) begin
      wr(OFS_CNT_SOURCE, 32'(s));
      if (s == 1) rchk(OFS_CNT_STATE, {29'h0, RD_ARMED});
      drive(s, 1'b1);
      run_len(0, 1'b0, ln, wt);
      `CHK(ln, 8)
      `CHK(cfin[0], 1'b1)
      drive(s, 1'b0);
    end
    rchk(OFS_CNT_STATE, {29'h0, RD_DONE});
    rchk(OFS_CNT_VALUE, 32'h7);
    // falling and any-edge activation on io line 0
    wr(OFS_CNT_SOURCE, 32'd9);
    wr(OFS_CNT_ACT, {29'h0, ACT_FALL});
    io_line[0] <= 1'b1;
    run_len(0, 1'b0, ln, wt);
    `CHK(ln, 0)
    io_line[0] <= 1'b0;
    run_len(0, 1'b0, ln, wt);
    `CHK(ln, 8)
    wr(OFS_CNT_ACT, {29'h0, ACT_ANY});
    io_line[0] <= 1'b1;
    run_len(0, 1'b0, ln, wt);
    `CHK(ln, 8)
    // level-low counting pauses and resumes
    wr(OFS_CNT_LENGTH, 32'd30);
    wr(OFS_CNT_ACT, {29'h0, ACT_LOW});
    io_line[0] <= 1'b0;
    fork
      run_len(0, 1'b0, ln, wt);
      begin
        repeat (14) @(posedge core_clk);
        io_line[0] <= 1'b1;
      end
    join
    rchk(OFS_CNT_STATE, {29'h0, RD_ARMED});
    bus(1'b0, OFS_CNT_VALUE, 32'h0, 4'hf);
    `CHK(rd != 32'h0, 1'b1)
    io_line[0] <= 1'b0;
    run_len(0, 1'b0, ln2, wt);
    io_line[0] <= 1'b1;
    // length 30 counted, plus one idle active cycle at the pause and at done
    `CHK(ln + ln2, 30 + 2)
    // source off ignores triggers
    wr(OFS_CNT_SOURCE, 32'd0);
    rchk(OFS_CNT_STATE, {29'h0, RD_IDLE});
    acq_events[0] <= 1'b1;
    run_len(0, 1'b0, ln, wt);
    `CHK(ln, 0)
    acq_events[0] <= 1'b0;
    // counter 1 cascaded behind counter 0
    wr(OFS_SELECT, 32'h1);
    wr(OFS_CNT_SOURCE, 32'd13);
    wr(OFS_CNT_LENGTH, 32'd3);
    wr(OFS_SELECT, 32'h0);
    wr(OFS_CNT_ACT, {29'h0, ACT_RISE});
    wr(OFS_CNT_LENGTH, 32'd7);
    wr(OFS_CNT_SOURCE, 32'd1);
    acq_events[0] <= 1'b1;
    run_len(0, 1'b0, ln, wt);
    run_len(1, 1'b0, ln, wt);
    `CHK(ln, 4)
    `CHK(cfin[1], 1'b1)
    // timer 0 end starts counter 1
    wr(OFS_SELECT, 32'h1);
    wr(OFS_CNT_SOURCE, 32'd15);
    wr(OFS_SELECT, 32'h0);
    wr(OFS_TMR_DLY_US, 32'h0);
    wr(OFS_TMR_LEN_NAT, 32'h4);
    wr(OFS_TMR_SOURCE, 32'd2);
    acq_events[1] <= 1'b1;
    run_len(0, 1'b1, ln, wt);
    `CHK(pfin[0], 1'b1)
    `CHK(ln >= 3 * TICK_CYCLES && ln <= 5 * TICK_CYCLES, 1'b1)
    run_len(1, 1'b0, ln, wt);
    `CHK(ln, 4)
    rchk(OFS_TMR_STATE, 32'h3);
    rchk(OFS_TMR_ELAPSED, 32'h4 >> NAT_PER_US_SHIFT);
    repeat (30) @(posedge core_clk);
    `CHK(prun[0], 1'b0)
    wr(OFS_COMMAND, 32'h2);
    rchk(OFS_TMR_STATE, 32'h1);
    // delay before the pulse
    acq_events[1] <= 1'b0;
    wr(OFS_TMR_DLY_US, 32'h2);
    acq_events[1] <= 1'b1;
    run_len(0, 1'b1, ln, wt);
    `CHK(wt >= 3 * TICK_CYCLES && wt <= 6 * TICK_CYCLES, 1'b1)
    // clear catches the running value and restarts
    acq_events[0] <= 1'b0;
    wr(OFS_CNT_LENGTH, 32'd1000);
    acq_events[0] <= 1'b1;
    repeat (50) @(posedge core_clk);
    wr(OFS_COMMAND, 32'h1);
    `CHK(crun[0], 1'b1)
    bus(1'b0, OFS_CNT_CAPT, 32'h0, 4'hf);
    `CHK(rd >= 32'd45 && rd < 32'd100, 1'b1)
    // reset in mid-run clears configuration
    rst <= 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `CHK(crun[0], 1'b0)
    rchk(OFS_CNT_SOURCE, 32'h0);
    test_done();
  end
endmodule // testbench
